// [logic/dcmct_core_ctrl.sv]
// Purpose: core update scheme, clock duty and phase trims, shuffle control
// Assumes: one ref_clk_in cycle is one half period of the converter clock
// Notes:   configuration over a four-wire serial port, 16-bit instruction
`timescale 1ns/10ps
module dcmct_core_ctrl
    import dcmct_pkg::*;
(
    input  wire logic                ref_clk_in,
    input  wire logic                rst_n_in,
    input  wire logic                spi_sclk_in,
    input  wire logic                spi_csn_in,
    input  wire logic                spi_sdi_in,
    output logic                     spi_sdo_out,
    output logic                     spi_sdo_oe_out,
    input  wire logic                sample_valid_in,
    input  wire logic [SAMPLE_W-1:0] sample_data_in,
    output logic                     sample_ready_out,
    output logic      [SAMPLE_W-1:0] core_code_out,
    output logic                     switch_pair_a_en_out,
    output logic                     switch_pair_b_en_out,
    output logic      [SEG_N-1:0]    msb_segments_out,
    output logic      [LSB_W-1:0]    lsb_bits_out,
    output logic                     duty_correct_en_out,
    output logic                     duty_offset_en_out,
    output logic                     duty_offset_neg_out,
    output logic      [3:0]          duty_offset_mag_out,
    output logic      [4:0]          clk_pos_cap_steps_out,
    output logic      [4:0]          clk_neg_cap_steps_out
);
    typedef struct packed {
        // serial port: sync stages are {csn, sclk, sdi}
        logic [2:0]       sync1;
        logic [2:0]       sync2;
        logic             sclk_prev;
        dcmct_spi_state_t spi_state;
        logic [4:0]       bit_cnt;
        logic [15:0]      shift_in;
        logic [7:0]       shift_out;
        logic             rd;
        logic [14:0]      addr;
        logic             sdo;
        logic             sdo_oe;
        // configuration registers
        logic [7:0]       phase_reg;
        logic [7:0]       duty_reg;
        logic [7:0]       shuf_reg;
        logic [7:0]       mode_reg;
        // core update
        logic             half;
        logic [15:0]      sample;
        logic [15:0]      core_code;
        logic             pair_a;
        logic             pair_b;
        // trims
        logic             duty_en;
        logic             duty_ofs_en;
        logic             duty_neg;
        logic [3:0]       duty_mag;
        logic [4:0]       cap_pos;
        logic [4:0]       cap_neg;
    } dcmct_core_state_t;

    dcmct_core_state_t st;
    dcmct_core_state_t nx;
    logic              sclk_rise;
    logic              sclk_fall;
    logic [15:0]       instr_word;
    logic [7:0]        data_byte;

    dcmct_stream_if #(.W(SAMPLE_W)) in_if ();
    dcmct_stream_if #(.W(SAMPLE_W)) out_if ();

    assign in_if.valid      = sample_valid_in;
    assign in_if.data       = sample_data_in;
    assign sample_ready_out = in_if.ready;
    // samples are taken only at the rising half; a dry buffer repeats the last one
    assign out_if.ready     = !st.half;

    dcmct_fifo #(
        .W     (SAMPLE_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .ref_clk_in (ref_clk_in),
        .rst_n_in   (rst_n_in),
        .in_s       (in_if),
        .out_s      (out_if)
    );

    dcmct_shuffler u_shuffler (
        .code_in          (nx.core_code),
        .shuffle_en_in    (st.shuf_reg[SHUF_EN_BIT]),
        .ref_clk_in       (ref_clk_in),
        .rst_n_in         (rst_n_in),
        .msb_segments_out (msb_segments_out),
        .lsb_bits_out     (lsb_bits_out)
    );

    // read-back of a register; unmapped addresses and spare bits give zero
    function automatic logic [7:0] reg_read(input dcmct_core_state_t s, input logic [14:0] a);
        logic [7:0] d;
        d = 8'h00;
        unique case (a)
            REG_PHASE_ADDR: d = s.phase_reg;
            REG_DUTY_ADDR:  d = s.duty_reg;
            REG_SHUF_ADDR:  d = s.shuf_reg;
            REG_MODE_ADDR:  d = s.mode_reg;
            default:        d = 8'h00;
        endcase
        return d;
    endfunction : reg_read

    // rounded-down midpoint of two codes, used by the two-times filter
    function automatic logic [15:0] midpoint(input logic [15:0] a, input logic [15:0] b);
        logic [16:0] s;
        s = {1'b0, a} + {1'b0, b};
        return s[16:1];
    endfunction : midpoint

    // edge detect looks only at the second sync stage and its delayed copy
    assign sclk_rise  = st.sync2[1] & !st.sclk_prev;
    assign sclk_fall  = !st.sync2[1] & st.sclk_prev;
    assign instr_word = {st.shift_in[14:0], st.sync2[0]};
    assign data_byte  = {st.shift_in[6:0], st.sync2[0]};

    // serial port: instruction bit 15 set means read, bits 14:0 the address
    always_comb begin
        nx           = st;
        nx.sync1     = {spi_csn_in, spi_sclk_in, spi_sdi_in};
        nx.sync2     = st.sync1;
        nx.sclk_prev = st.sync2[1];
        if (st.sync2[2]) begin
            nx.spi_state = SPI_IDLE;
            nx.sdo_oe    = 1'b0;
            nx.bit_cnt   = 5'h00;
        end else begin
            unique case (st.spi_state)
                SPI_IDLE: begin
                    nx.spi_state = SPI_INSTR;
                    nx.bit_cnt   = 5'h00;
                end
                SPI_INSTR: begin
                    if (sclk_rise) begin
                        nx.shift_in = instr_word;
                        nx.bit_cnt  = st.bit_cnt + 5'h01;
                        if (st.bit_cnt == SPI_INSTR_LAST) begin
                            nx.rd        = instr_word[15];
                            nx.addr      = instr_word[14:0];
                            nx.shift_out = reg_read(st, instr_word[14:0]);
                            nx.bit_cnt   = 5'h00;
                            nx.spi_state = SPI_DATA;
                        end
                    end
                end
                SPI_DATA: begin
                    if (sclk_fall && st.rd) begin
                        nx.sdo       = st.shift_out[7];
                        nx.sdo_oe    = 1'b1;
                        nx.shift_out = {st.shift_out[6:0], 1'b0};
                    end
                    if (sclk_rise) begin
                        nx.shift_in = instr_word;
                        nx.bit_cnt  = st.bit_cnt + 5'h01;
                        if (st.bit_cnt == SPI_DATA_LAST) begin
                            nx.bit_cnt   = 5'h00;
                            nx.shift_out = reg_read(st, st.addr);
                            if (!st.rd) begin
                                unique case (st.addr)
                                    REG_PHASE_ADDR: nx.phase_reg = data_byte & REG_PHASE_MASK;
                                    REG_DUTY_ADDR:  nx.duty_reg  = data_byte & REG_DUTY_MASK;
                                    REG_SHUF_ADDR:  nx.shuf_reg  = data_byte & REG_SHUF_MASK;
                                    REG_MODE_ADDR:  nx.mode_reg  = data_byte & REG_MODE_MASK;
                                    default:        nx.addr      = st.addr;
                                endcase
                            end
                        end
                    end
                end
                default: begin
                    nx.spi_state = SPI_IDLE;
                end
            endcase
        end

        // core update: alternate halves drive alternate switch pairs
        nx.half   = !st.half;
        nx.pair_a = !st.half;
        nx.pair_b = st.half;
        if (!st.half) begin
            if (out_if.valid) begin
                nx.sample = out_if.data;
            end
            nx.core_code = out_if.valid ? out_if.data : st.sample;
        end else begin
            unique case (st.mode_reg[1:0])
                MODE_ZERO_HALF: nx.core_code = CORE_ZERO_CODE;
                MODE_MIX:       nx.core_code = ~st.sample;
                default: begin
                    // the filter output sits between this sample and the next queued one
                    if (st.mode_reg[INTERP_EN_BIT]) begin
                        nx.core_code = midpoint(st.sample, out_if.valid ? out_if.data : st.sample);
                    end else begin
                        nx.core_code = st.sample;
                    end
                end
            endcase
        end

        // trims follow the registers one cycle later
        nx.duty_en     = st.duty_reg[DUTY_EN_BIT];
        nx.duty_ofs_en = st.duty_reg[DUTY_OFS_EN_BIT];
        nx.duty_neg    = st.duty_reg[DUTY_SIGN_BIT];
        nx.duty_mag    = st.duty_reg[3:0];
        nx.cap_pos     = st.phase_reg[PHASE_SIGN_BIT] ? 5'h00 : st.phase_reg[4:0];
        nx.cap_neg     = st.phase_reg[PHASE_SIGN_BIT] ? st.phase_reg[4:0] : 5'h00;
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st           <= '0;
            st.sync1     <= 3'h7;
            st.sync2     <= 3'h7;
            st.spi_state <= SPI_IDLE;
            st.phase_reg <= REG_PHASE_RST;
            st.duty_reg  <= REG_DUTY_RST;
            st.shuf_reg  <= REG_SHUF_RST;
            st.mode_reg  <= REG_MODE_RST;
            st.pair_b    <= 1'b1;
        end else begin
            st <= nx;
        end
    end

    assign spi_sdo_out           = st.sdo;
    assign spi_sdo_oe_out        = st.sdo_oe;
    assign core_code_out         = st.core_code;
    assign switch_pair_a_en_out  = st.pair_a;
    assign switch_pair_b_en_out  = st.pair_b;
    assign duty_correct_en_out   = st.duty_en;
    assign duty_offset_en_out    = st.duty_ofs_en;
    assign duty_offset_neg_out   = st.duty_neg;
    assign duty_offset_mag_out   = st.duty_mag;
    assign clk_pos_cap_steps_out = st.cap_pos;
    assign clk_neg_cap_steps_out = st.cap_neg;

    property p_pair_alt;
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        (st.pair_a ^ st.pair_b) and (st.pair_a |=> st.pair_b ##1 st.pair_a);
    endproperty
    a_pair_alt: assert property (p_pair_alt) else $error("switch pairs not alternating");

    property p_zero_half;
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        (st.half && st.mode_reg[1:0] == MODE_ZERO_HALF) |=> (core_code_out == CORE_ZERO_CODE) && st.pair_b;
    endproperty
    a_zero_half: assert property (p_zero_half) else $error("falling half not zero");

    property p_mix_half;
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        (st.half && st.mode_reg[1:0] == MODE_MIX) |=> (core_code_out == ~$past(core_code_out));
    endproperty
    a_mix_half: assert property (p_mix_half) else $error("falling half not complement");

    property p_hold_half;
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        (st.half && st.mode_reg == REG_MODE_RST) |=> $stable(core_code_out);
    endproperty
    a_hold_half: assert property (p_hold_half) else $error("hold mode changed mid period");

    property p_interp_half;
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        (st.half && st.mode_reg[1:0] == MODE_NRZ && st.mode_reg[INTERP_EN_BIT] && out_if.valid)
            |=> (core_code_out == midpoint($past(st.sample), $past(out_if.data)));
    endproperty
    a_interp_half: assert property (p_interp_half) else $error("filter half sample wrong");

    property p_duty_bits;
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        $changed(st.duty_reg) |=> (duty_correct_en_out == $past(st.duty_reg[7]))
            && (duty_offset_en_out == $past(st.duty_reg[6]));
    endproperty
    a_duty_bits: assert property (p_duty_bits) else $error("duty enables not applied");

    property p_duty_offset;
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        $changed(st.duty_reg) |=> ({duty_offset_neg_out, duty_offset_mag_out} == $past(st.duty_reg[4:0]));
    endproperty
    a_duty_offset: assert property (p_duty_offset) else $error("duty offset not applied");

    property p_phase_split;
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        st.phase_reg[5] |=> (clk_pos_cap_steps_out == 5'h00)
            && (clk_neg_cap_steps_out == $past(st.phase_reg[4:0]));
    endproperty
    a_phase_split: assert property (p_phase_split) else $error("phase steps on wrong input");

    // spare bits, the positive phase side, the rising half, mode 11 and the read enable
    property p_spare_zero;
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        ((st.phase_reg & ~REG_PHASE_MASK) | (st.duty_reg & ~REG_DUTY_MASK)
            | (st.shuf_reg & ~REG_SHUF_MASK) | (st.mode_reg & ~REG_MODE_MASK)) == 8'h00;
    endproperty
    a_spare_zero: assert property (p_spare_zero) else $error("spare bits set");

    property p_phase_pos;
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        !st.phase_reg[PHASE_SIGN_BIT] |=> (clk_neg_cap_steps_out == 5'h00)
            && (clk_pos_cap_steps_out == $past(st.phase_reg[4:0]));
    endproperty
    a_phase_pos: assert property (p_phase_pos) else $error("positive steps wrong");

    property p_rise_load;
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        (!st.half) |=> switch_pair_a_en_out && (core_code_out == $past(out_if.valid ? out_if.data : st.sample));
    endproperty
    a_rise_load: assert property (p_rise_load) else $error("rising half not the sample");

    property p_mode_spare;
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        (st.half && st.mode_reg[1:0] != MODE_NRZ && st.mode_reg[1:0] != MODE_MIX
            && st.mode_reg[1:0] != MODE_ZERO_HALF && !st.mode_reg[INTERP_EN_BIT]) |=> $stable(core_code_out);
    endproperty
    a_mode_spare: assert property (p_mode_spare) else $error("mode 11 not held");

    property p_oe_read;
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        spi_sdo_oe_out |-> st.rd && (st.spi_state == SPI_DATA);
    endproperty
    a_oe_read: assert property (p_oe_read) else $error("read enable outside read data");
endmodule : dcmct_core_ctrl

// [logic/dcmct_pkg.sv]
// Purpose: shared constants and types for the converter core control block
// Assumes: 8-bit configuration registers on a 15-bit serial address space
// Notes:   sample codes are 16-bit offset binary, top four bits are segmented
package dcmct_pkg;
    // register addresses
    localparam logic [14:0] REG_PHASE_ADDR  = 15'h007F;
    localparam logic [14:0] REG_DUTY_ADDR   = 15'h0082;
    localparam logic [14:0] REG_SHUF_ADDR   = 15'h0151;
    localparam logic [14:0] REG_MODE_ADDR   = 15'h0152;
    // reset values
    localparam logic [7:0]  REG_PHASE_RST   = 8'h00;
    localparam logic [7:0]  REG_DUTY_RST    = 8'h00;
    localparam logic [7:0]  REG_SHUF_RST    = 8'h00;
    localparam logic [7:0]  REG_MODE_RST    = 8'h00;
    // writable bit masks, everything else reads zero
    localparam logic [7:0]  REG_PHASE_MASK  = 8'h3F;
    localparam logic [7:0]  REG_DUTY_MASK   = 8'hDF;
    localparam logic [7:0]  REG_SHUF_MASK   = 8'h04;
    localparam logic [7:0]  REG_MODE_MASK   = 8'h07;
    // field positions
    localparam int          DUTY_EN_BIT     = 7;
    localparam int          DUTY_OFS_EN_BIT = 6;
    localparam int          DUTY_SIGN_BIT   = 4;
    localparam int          PHASE_SIGN_BIT  = 5;
    localparam int          SHUF_EN_BIT     = 2;
    localparam int          INTERP_EN_BIT   = 2;
    // core update modes
    localparam logic [1:0]  MODE_NRZ        = 2'h0;
    localparam logic [1:0]  MODE_MIX        = 2'h1;
    localparam logic [1:0]  MODE_ZERO_HALF  = 2'h2;
    // datapath sizes
    localparam int          SAMPLE_W        = 16;
    localparam int          MSB_W           = 4;
    localparam int          SEG_N           = 15;
    localparam int          LSB_W           = 12;
    localparam int          FIFO_DEPTH      = 4;
    localparam logic [15:0] CORE_ZERO_CODE  = 16'h0000;
    localparam logic [7:0]  LFSR_SEED       = 8'h01;
    // serial port framing
    localparam logic [4:0]  SPI_INSTR_LAST  = 5'h0F;
    localparam logic [4:0]  SPI_DATA_LAST   = 5'h07;

    typedef enum logic [2:0] {
        SPI_IDLE  = 3'h1,
        SPI_INSTR = 3'h2,
        SPI_DATA  = 3'h4
    } dcmct_spi_state_t;
endpackage : dcmct_pkg

// [logic/dcmct_stream_if.sv]
// Purpose: valid/ready sample stream between the block's own modules
// Assumes: single clock domain
// Notes:   data is held by the source while valid is high and ready low
`timescale 1ns/10ps
interface dcmct_stream_if #(parameter int W = 16);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : dcmct_stream_if

// [logic/dcmct_fifo.sv]
// Purpose: small sample buffer in front of the core update logic
// Assumes: depth is a power of two
// Notes:   input ready is registered so it can drive a top-level port directly
`timescale 1ns/10ps
module dcmct_fifo #(
    parameter int W     = 16,
    parameter int DEPTH = 4
) (
    input  wire logic    ref_clk_in,
    input  wire logic    rst_n_in,
    dcmct_stream_if.snk  in_s,
    dcmct_stream_if.src  out_s
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0]           wr_ptr;
        logic [AW-1:0]           rd_ptr;
        logic [AW:0]             count;
        logic                    in_ready;
    } dcmct_fifo_state_t;

    dcmct_fifo_state_t st;
    dcmct_fifo_state_t nx;
    logic              push;
    logic              pop;

    assign out_s.valid = (st.count != '0);
    assign out_s.data  = st.mem[st.rd_ptr];
    assign in_s.ready  = st.in_ready;
    assign push        = in_s.valid & st.in_ready;
    assign pop         = out_s.valid & out_s.ready;

    // pointer and count update; ready drops in the same cycle the last slot fills
    always_comb begin
        nx = st;
        if (push) begin
            nx.mem[st.wr_ptr] = in_s.data;
            nx.wr_ptr         = st.wr_ptr + 1'b1;
        end
        if (pop) begin
            nx.rd_ptr = st.rd_ptr + 1'b1;
        end
        nx.count    = st.count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        nx.in_ready = (nx.count < (AW+1)'(DEPTH));
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st          <= '0;
            st.in_ready <= 1'b1;
        end else begin
            st <= nx;
        end
    end
endmodule : dcmct_fifo

// [logic/dcmct_shuffler.sv]
// Purpose: maps a core code onto segment and binary current switches
// Assumes: top bits drive equal-weight segments, low bits binary-weighted
// Notes:   rotation keeps the count of lit segments, so the output level holds
`timescale 1ns/10ps
module dcmct_shuffler
    import dcmct_pkg::*;
(
    input  wire logic [SAMPLE_W-1:0] code_in,
    input  wire logic                shuffle_en_in,
    input  wire logic                ref_clk_in,
    input  wire logic                rst_n_in,
    output logic      [SEG_N-1:0]    msb_segments_out,
    output logic      [LSB_W-1:0]    lsb_bits_out
);
    typedef struct packed {
        logic [7:0]       lfsr;
        logic [SEG_N-1:0] seg;
        logic [LSB_W-1:0] lsb;
    } dcmct_shuf_state_t;

    dcmct_shuf_state_t st;
    dcmct_shuf_state_t nx;

    function automatic logic [SEG_N-1:0] therm(input logic [MSB_W-1:0] n);
        logic [31:0] t;
        t = (32'h1 << n) - 32'h1;
        return t[SEG_N-1:0];
    endfunction : therm

    function automatic logic [SEG_N-1:0] rotl(input logic [SEG_N-1:0] v, input logic [3:0] k);
        logic [2*SEG_N-1:0] d;
        d = {v, v} << k;
        return d[2*SEG_N-1:SEG_N];
    endfunction : rotl

    // lfsr free-runs so the pattern is not tied to the data
    always_comb begin
        nx      = st;
        nx.lfsr = {st.lfsr[6:0], st.lfsr[7] ^ st.lfsr[5] ^ st.lfsr[4] ^ st.lfsr[3]};
        if (shuffle_en_in) begin
            nx.seg = rotl(therm(code_in[SAMPLE_W-1 -: MSB_W]), 4'(st.lfsr % 8'h0F));
        end else begin
            nx.seg = therm(code_in[SAMPLE_W-1 -: MSB_W]);
        end
        nx.lsb = code_in[LSB_W-1:0];
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st      <= '0;
            st.lfsr <= LFSR_SEED;
        end else begin
            st <= nx;
        end
    end

    assign msb_segments_out = st.seg;
    assign lsb_bits_out     = st.lsb;

    property p_lsb_pass;
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        1'b1 |=> (lsb_bits_out == $past(code_in[LSB_W-1:0]));
    endproperty
    a_lsb_pass: assert property (p_lsb_pass) else $error("low bits were reordered");

    property p_shuffle_level;
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        1'b1 |=> ($countones(msb_segments_out) == int'($past(code_in[SAMPLE_W-1 -: MSB_W])));
    endproperty
    a_shuffle_level: assert property (p_shuffle_level) else $error("segment count wrong");

    property p_shuffle_off;
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        !shuffle_en_in |=> (msb_segments_out == therm($past(code_in[SAMPLE_W-1 -: MSB_W])));
    endproperty
    a_shuffle_off: assert property (p_shuffle_off) else $error("segments moved while off");
endmodule : dcmct_shuffler

// [dv/dcmct_host_model.sv]
// Purpose: serial configuration host for the four-wire port
// Assumes: six reference cycles per sclk phase, above the sync minimum
// Notes:   sclk rests low between frames; read data taken at each sclk rise
`timescale 1ns/10ps
module dcmct_host_model (
    input  wire logic ref_clk_in,
    input  wire logic spi_sdo_in,
    output logic      spi_sclk_out,
    output logic      spi_csn_out,
    output logic      spi_sdi_out
);
    initial begin
        spi_sclk_out = 1'b0;
        spi_csn_out  = 1'b1;
        spi_sdi_out  = 1'b0;
    end
    // one whole frame, msb first; the address is sent as given, mapped or not
    task automatic xfer(input logic r, input logic [14:0] a, input logic [7:0] w, output logic [7:0] v);
        logic [23:0] sh;
        sh = {r, a, w};
        v = 8'h00;
        @(posedge ref_clk_in);
        spi_csn_out <= 1'b0;
        for (int i = 23; i >= 0; i--) begin
            spi_sdi_out <= sh[i];
            repeat (6) @(posedge ref_clk_in);
            spi_sclk_out <= 1'b1;
            if (i < 8) v[i] = spi_sdo_in;
            repeat (6) @(posedge ref_clk_in);
            spi_sclk_out <= 1'b0;
        end
        // let the write land before the frame closes
        repeat (10) @(posedge ref_clk_in);
        spi_csn_out <= 1'b1;
        repeat (10) @(posedge ref_clk_in);
    endtask : xfer
endmodule : dcmct_host_model

// [dv/tb_top.sv]
// Purpose: self-checking bench for the converter core control block
// Assumes: 200 MHz reference clock, one cycle per converter half period
// Notes:   samples are offered one or two at a time, so the core repeats the last one
`timescale 1ns/10ps
module tb_top
    import dcmct_pkg::*;
;
    logic        clk = 1'b0, rst_n = 1'b0, sclk, csn, sdi, sdo, oe, sv = 1'b0, rdy, pa, pb, dce, doe, dng;
    logic [15:0] sd = 16'h0000, code;
    logic [14:0] seg;
    logic [11:0] lsb;
    logic [3:0]  dmag;
    logic [4:0]  cpos, cneg;
    int          err_count = 0, cmp_count = 0;
    always #2.5 clk = ~clk;
    dcmct_host_model dcmct_host_model_inst (.ref_clk_in(clk), .spi_sdo_in(sdo), .spi_sclk_out(sclk),
        .spi_csn_out(csn), .spi_sdi_out(sdi));
    dcmct_core_ctrl dcmct_core_ctrl_inst (.ref_clk_in(clk), .rst_n_in(rst_n), .spi_sclk_in(sclk),
        .spi_csn_in(csn), .spi_sdi_in(sdi), .spi_sdo_out(sdo), .spi_sdo_oe_out(oe), .sample_valid_in(sv),
        .sample_data_in(sd), .sample_ready_out(rdy), .core_code_out(code), .switch_pair_a_en_out(pa),
        .switch_pair_b_en_out(pb), .msb_segments_out(seg), .lsb_bits_out(lsb), .duty_correct_en_out(dce),
        .duty_offset_en_out(doe), .duty_offset_neg_out(dng), .duty_offset_mag_out(dmag),
        .clk_pos_cap_steps_out(cpos), .clk_neg_cap_steps_out(cneg));
    task results();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : results
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            err_count++;
            $display("[FAIL] %s exp %0h got %0h", nm, e, g);
        end
    endtask : chk
    task wr(input logic [14:0] a, input logic [7:0] d);
        logic [7:0] x;
        dcmct_host_model_inst.xfer(1'b0, a, d, x);
    endtask : wr
    task rdc(input logic [14:0] a, input logic [7:0] e);
        logic [7:0] x;
        dcmct_host_model_inst.xfer(1'b1, a, 8'h00, x);
        chk("readback", e, x);
    endtask : rdc
    // hold valid until an edge sees ready, bounded
    task push(input logic [15:0] s);
        int n;
        @(posedge clk);
        sv <= 1'b1;
        sd <= s;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (rdy !== 1'b1 && n < 20);
        chk("push taken", 1, rdy);
        sv <= 1'b0;
    endtask : push
    // find a rising half, then judge it and the falling half after it
    task halves(input logic [15:0] s, input logic [15:0] f);
        repeat (12) @(posedge clk);
        #1;
        for (int n = 0; n < 3 && pa !== 1'b1; n++) #5;
        chk("rise code", s, code);
        chk("pair b off", 0, pb);
        chk("lsb pass", s[11:0], lsb);
        chk("segments lit", s[15:12], $countones(seg));
        #5;
        chk("fall pairs", 2'b01, {pa, pb});
        chk("fall code", f, code);
    endtask : halves
    task t_reset();
        repeat (20) @(posedge clk);
        chk("reset state", 4'b0110, {pa, pb, rdy, oe});
        rst_n <= 1'b1;
        rdc(REG_PHASE_ADDR, 8'h00);
        rdc(REG_MODE_ADDR, 8'h00);
        rdc(15'h0123, 8'h00);
    endtask : t_reset
    task t_modes();
        logic [1:0] m [4] = '{MODE_NRZ, MODE_ZERO_HALF, MODE_MIX, 2'h3};
        logic [15:0] s;
        for (int i = 0; i < 4; i++) begin
            s = 16'hA5C3 ^ 16'(i);
            wr(REG_MODE_ADDR, {6'h00, m[i]});
            push(s);
            #1;
            halves(s, m[i] == MODE_MIX ? ~s : m[i] == MODE_ZERO_HALF ? CORE_ZERO_CODE : s);
        end
    endtask : t_modes
    task t_shuffle();
        int moved;
        wr(REG_SHUF_ADDR, 8'hFF);
        rdc(REG_SHUF_ADDR, 8'h04);
        wr(REG_MODE_ADDR, 8'h00);
        push(16'hC123);
        #1;
        halves(16'hC123, 16'hC123);
        // a held code must still see its lit segments move around
        moved = 0;
        repeat (8) begin
            @(posedge clk);
            if (seg !== 15'h0FFF) moved++;
        end
        chk("segments moved", 1, moved > 0);
        wr(15'h0123, 8'h5A);
        rdc(15'h0123, 8'h00);
    endtask : t_shuffle
    // two samples on back-to-back edges, so the second is queued at the falling half
    task t_interp();
        wr(REG_MODE_ADDR, 8'h04);
        #1;
        while (pa !== 1'b1) #5;
        @(posedge clk);
        sv <= 1'b1;
        sd <= 16'h1000;
        @(posedge clk);
        sd <= 16'h3000;
        @(posedge clk);
        sv <= 1'b0;
        #6;
        chk("filter rise", 16'h1000, code);
        #5;
        chk("filter fall", 16'h2000, code);
    endtask : t_interp
    task t_trims();
        wr(REG_DUTY_ADDR, 8'hFF);
        rdc(REG_DUTY_ADDR, 8'hDF);
        chk("duty full", 7'h7F, {dce, doe, dng, dmag});
        wr(REG_DUTY_ADDR, 8'h4A);
        chk("duty pos", 7'h2A, {dce, doe, dng, dmag});
        wr(REG_PHASE_ADDR, 8'h25);
        chk("phase neg", 10'h005, {cpos, cneg});
        wr(REG_PHASE_ADDR, 8'h1F);
        chk("phase pos", 10'h3E0, {cpos, cneg});
        wr(REG_PHASE_ADDR, 8'hE0);
        rdc(REG_PHASE_ADDR, 8'h20);
        chk("phase zero", 10'h000, {cpos, cneg});
    endtask : t_trims
    initial begin
        t_reset();
        t_modes();
        t_shuffle();
        t_interp();
        t_trims();
        results();
    end
    // the tests need about 6300 cycles
    initial begin
        #400000;
        err_count++;
        results();
    end
endmodule : tb_top
